// ==== pat_defs.svh ====
// Constants of the 8-bit auto-reload PWM timer: APB offsets, field positions, resets.
// Assumes a 32-bit APB with word-aligned registers, data in bits 7:0.
`ifndef PAT_DEFS_SVH
`define PAT_DEFS_SVH

`define PAT_OFS_CSR 8'h00
`define PAT_OFS_CAR 8'h04
`define PAT_OFS_ARR 8'h08
`define PAT_OFS_PCR 8'h0c
`define PAT_OFS_DUTY0 8'h10
`define PAT_OFS_DUTY1 8'h14
`define PAT_OFS_DUTY2 8'h18
`define PAT_OFS_DUTY3 8'h1c
`define PAT_OFS_ICCSR 8'h20
`define PAT_OFS_ICR1 8'h24
`define PAT_OFS_ICR2 8'h28

`define PAT_CSR_EXTERNAL_CLOCK_SELECT 7
`define PAT_CSR_CC_HI 6
`define PAT_CSR_CC_LO 4
`define PAT_CSR_TCE 3
`define PAT_CSR_FORCE_RELOAD 2
`define PAT_CSR_OIE 1
`define PAT_CSR_OVF 0

`define PAT_PCR_OE_LO 4
`define PAT_ICC_CS_LO 4
`define PAT_ICC_CIE_LO 2
`define PAT_ICC_CF_LO 0

`define PAT_RST_BYTE 8'h00
`define PAT_CNT_MAX 8'hff

`endif

// ==== pat_pkg.sv ====
// Types of the 8-bit auto-reload PWM timer.
// Assumes pat_defs.svh holds the numeric constants.
package pat_pkg;
    // Software-written timer controls
    typedef struct packed {
        logic external_clock_select;
        logic [2:0] div_sel;
        logic cnt_en;
        logic ovf_ie;
    } pat_ctrl_s;

    // Per-channel PWM controls
    typedef struct packed {
        logic [3:0] oe;
        logic [3:0] pol;
    } pat_pwm_s;

    // Capture controls
    typedef struct packed {
        logic [1:0] edge_rise;
        logic [1:0] ie;
    } pat_cap_s;
endpackage

// ==== pat_timer.sv ====
// 8-bit auto-reload timer with prescaler, four PWM outputs and two captures, APB slave.
// Assumes clk at 20 MHz, async active-low reset, pins asynchronous to clk.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ns
`include "pat_defs.svh"

module pat_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic external_tick,
    input wire logic [1:0] capture_pin,
    output logic [3:0] pulse_out,
    output logic [3:0] pulse_oe,
    // System
    input wire logic deep_stop,
    output logic overflow_irq,
    output logic capture_irq,
    output logic wakeup
);

    // Tap hit: low n prescaler bits all ones
    // A tick leaves the prescaler when its low n bits roll over together
    function automatic logic tap_hit(input logic [6:0] p, input logic [2:0] n);
        logic [6:0] m;
        m = 7'((8'h01 << n) - 8'h01);
        return (p & m) == m;
    endfunction

    // Software-visible registers and the hidden compare values
    pat_pkg::pat_ctrl_s ctrl_q;
    pat_pkg::pat_pwm_s pwm_q;
    pat_pkg::pat_cap_s cap_q;
    logic [7:0] reload_q;
    logic [7:0] duty_q [4];
    logic [7:0] cmp_q [4];

    // Counter, prescaler and sticky flags
    logic [7:0] cnt_q;
    logic [6:0] presc_q;
    logic ovf_q;
    logic [1:0] cf_q;
    logic [7:0] icr_q [2];

    // Pin synchroniser stages and accepted levels
    logic [2:0] ext_sync_q;
    logic ext_filt_q;
    logic [2:0] cap_sync_q [2];
    logic [1:0] cap_filt_q;

    // Registers behind the outputs
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [3:0] pulse_q;
    logic [3:0] pulse_oe_q;
    logic ovf_irq_q;
    logic cap_irq_q;
    logic wake_q;

    // Bus phase decode
    // The access phase is answered on its second cycle
    logic acc_start;
    logic acc_done;
    logic wr_done;
    logic rd_done;
    logic regs_open;
    logic mapped;

    assign acc_start = psel && penable && !pready_q;
    assign acc_done = psel && penable && pready_q;
    assign wr_done = acc_done && pwrite;
    assign rd_done = acc_done && !pwrite;
    // Control registers freeze in deep stop
    assign regs_open = wr_done && !deep_stop;

    always_comb begin
        unique case (paddr)
            `PAT_OFS_CSR, `PAT_OFS_CAR, `PAT_OFS_ARR, `PAT_OFS_PCR,
            `PAT_OFS_DUTY0, `PAT_OFS_DUTY1, `PAT_OFS_DUTY2, `PAT_OFS_DUTY3,
            `PAT_OFS_ICCSR, `PAT_OFS_ICR1, `PAT_OFS_ICR2: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Pin synchronisers: three flops, accept when stages two and three agree
    // A level that stages two and three disagree on is a glitch and is ignored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync_q <= 3'h0;
            ext_filt_q <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], external_tick};
            if (ext_sync_q[1] == ext_sync_q[2]) begin
                ext_filt_q <= ext_sync_q[2];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_sync_q[0] <= 3'h0;
            cap_sync_q[1] <= 3'h0;
            cap_filt_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                cap_sync_q[i] <= {cap_sync_q[i][1:0], capture_pin[i]};
                if (cap_sync_q[i][1] == cap_sync_q[i][2]) begin
                    cap_filt_q[i] <= cap_sync_q[i][2];
                end
            end
        end
    end

    // Tick generation
    logic ext_rise;
    logic in_tick;
    logic run;
    logic cnt_tick;
    logic ovf_evt;
    logic car_wr;
    logic force_reload_wr;
    logic [1:0] cap_evt;

    assign ext_rise = ext_sync_q[2] && !ext_filt_q && (ext_sync_q[1] == ext_sync_q[2]);
    assign in_tick = ctrl_q.external_clock_select ? ext_rise : 1'b1;
    // Core clock stops in deep stop; external input keeps counting
    assign run = ctrl_q.cnt_en && (!deep_stop || ctrl_q.external_clock_select);
    assign cnt_tick = run && in_tick && tap_hit(presc_q, ctrl_q.div_sel);
    assign ovf_evt = cnt_tick && (cnt_q == `PAT_CNT_MAX);
    assign car_wr = regs_open && (paddr == `PAT_OFS_CAR);
    assign force_reload_wr = regs_open && (paddr == `PAT_OFS_CSR) && pwdata[`PAT_CSR_FORCE_RELOAD];

    // Capture edge detect on filtered levels
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cap_evt[i] = (cap_sync_q[i][1] == cap_sync_q[i][2]) && (cap_sync_q[i][2] != cap_filt_q[i])
                && (cap_sync_q[i][2] == cap_q.edge_rise[i]);
        end
    end

    // Prescaler
    // Cleared by counter writes and force reload so counting restarts cleanly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= 7'h00;
        end else if (car_wr || force_reload_wr) begin
            presc_q <= 7'h00;
        end else if (run && in_tick) begin
            presc_q <= presc_q + 7'h01;
        end
    end

    // Counter
    // Counter write beats force reload, which beats overflow and tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `PAT_RST_BYTE;
        end else if (car_wr) begin
            cnt_q <= pwdata[7:0];
        end else if (force_reload_wr) begin
            cnt_q <= reload_q;
        end else if (ovf_evt) begin
            cnt_q <= reload_q;
        end else if (cnt_tick) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Timer control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
        end else if (regs_open && paddr == `PAT_OFS_CSR) begin
            ctrl_q.external_clock_select <= pwdata[`PAT_CSR_EXTERNAL_CLOCK_SELECT];
            ctrl_q.div_sel <= pwdata[`PAT_CSR_CC_HI:`PAT_CSR_CC_LO];
            ctrl_q.cnt_en <= pwdata[`PAT_CSR_TCE];
            ctrl_q.ovf_ie <= pwdata[`PAT_CSR_OIE];
        end
    end

    // Overflow flag: set wins over the read clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_q <= 1'b0;
        end else if (ovf_evt) begin
            ovf_q <= 1'b1;
        end else if (rd_done && paddr == `PAT_OFS_CSR) begin
            ovf_q <= 1'b0;
        end
    end

    // Reload value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= `PAT_RST_BYTE;
        end else if (regs_open && paddr == `PAT_OFS_ARR) begin
            reload_q <= pwdata[7:0];
        end
    end

    // Output enables and polarities
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_q <= '0;
        end else if (regs_open && paddr == `PAT_OFS_PCR) begin
            pwm_q <= pwdata[7:0];
        end
    end

    // Duty buffers, picked up by the compares at overflow
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                duty_q[i] <= `PAT_RST_BYTE;
            end
        end else if (regs_open) begin
            unique case (paddr)
                `PAT_OFS_DUTY0: duty_q[0] <= pwdata[7:0];
                `PAT_OFS_DUTY1: duty_q[1] <= pwdata[7:0];
                `PAT_OFS_DUTY2: duty_q[2] <= pwdata[7:0];
                `PAT_OFS_DUTY3: duty_q[3] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Hidden compare values, double buffered
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                cmp_q[i] <= `PAT_RST_BYTE;
            end
        end else if (ovf_evt) begin
            for (int i = 0; i < 4; i++) begin
                cmp_q[i] <= duty_q[i];
            end
        end
    end

    // PWM outputs; levels hold in deep stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= 4'h0;
            pulse_oe_q <= 4'h0;
        end else if (!deep_stop) begin
            pulse_oe_q <= pwm_q.oe;
            for (int i = 0; i < 4; i++) begin
                // Reload value never exceeds compare when compare is programmed above it
                pulse_q[i] <= pwm_q.oe[i] && ((cnt_q <= cmp_q[i]) ^ pwm_q.pol[i]);
            end
        end
    end

    // Capture controls
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_q <= '0;
        end else if (regs_open && paddr == `PAT_OFS_ICCSR) begin
            cap_q.edge_rise <= pwdata[`PAT_ICC_CS_LO+1:`PAT_ICC_CS_LO];
            cap_q.ie <= pwdata[`PAT_ICC_CIE_LO+1:`PAT_ICC_CIE_LO];
        end
    end

    // Capture latches and flags
    // A set flag blocks new transfers until the value is read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cf_q <= 2'h0;
            icr_q[0] <= `PAT_RST_BYTE;
            icr_q[1] <= `PAT_RST_BYTE;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_evt[i] && !cf_q[i]) begin
                    icr_q[i] <= cnt_q;
                    cf_q[i] <= 1'b1;
                end else if (rd_done && paddr == (i == 0 ? `PAT_OFS_ICR1 : `PAT_OFS_ICR2)) begin
                    cf_q[i] <= 1'b0;
                end
            end
        end
    end

    // Overflow request follows flag and enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_irq_q <= 1'b0;
        end else begin
            ovf_irq_q <= ovf_q && ctrl_q.ovf_ie;
        end
    end

    // Capture request pends while any enabled flag is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_irq_q <= 1'b0;
        end else begin
            cap_irq_q <= |(cf_q & cap_q.ie);
        end
    end

    // Wakeup pulse in deep stop on an enabled overflow or capture edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= deep_stop && ((ovf_evt && ctrl_q.ovf_ie)
                || |(cap_evt & cap_q.ie));
        end
    end

    // Read data mux
    logic [7:0] rd_byte;
    always_comb begin
        unique case (paddr)
            `PAT_OFS_CSR: rd_byte = {ctrl_q.external_clock_select, ctrl_q.div_sel, ctrl_q.cnt_en, 1'b0,
                ctrl_q.ovf_ie, ovf_q};
            `PAT_OFS_CAR: rd_byte = cnt_q;
            `PAT_OFS_ARR: rd_byte = reload_q;
            `PAT_OFS_PCR: rd_byte = pwm_q;
            `PAT_OFS_DUTY0: rd_byte = duty_q[0];
            `PAT_OFS_DUTY1: rd_byte = duty_q[1];
            `PAT_OFS_DUTY2: rd_byte = duty_q[2];
            `PAT_OFS_DUTY3: rd_byte = duty_q[3];
            `PAT_OFS_ICCSR: rd_byte = {2'h0, cap_q.edge_rise, cap_q.ie, cf_q};
            `PAT_OFS_ICR1: rd_byte = icr_q[0];
            `PAT_OFS_ICR2: rd_byte = icr_q[1];
            default: rd_byte = 8'h00;
        endcase
    end

    // APB ready: one wait state after the first access cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= acc_start;
        end
    end

    // Read data captured with the wait state; writes answer zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (acc_start) begin
            prdata_q <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end
    end

    // Error for unmapped words, only alongside ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= acc_start && !mapped;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pulse_out = pulse_q;
    assign pulse_oe = pulse_oe_q;
    assign overflow_irq = ovf_irq_q;
    assign capture_irq = cap_irq_q;
    assign wakeup = wake_q;

endmodule

// ==== pat_timer_assertions.sv ====
// Checker of the PWM timer ports: bus handshake, flag clearing, pin outputs.
// Assumes it is bound to pat_timer and sees only its ports.
`timescale 1ns/1ns
`include "pat_defs.svh"

module pat_timer_assertions (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and system
    input wire logic [3:0] pulse_out,
    input wire logic [3:0] pulse_oe,
    input wire logic deep_stop,
    input wire logic overflow_irq,
    input wire logic capture_irq,
    input wire logic wakeup
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic done;
    logic csr_acc1_q;
    logic csr_acc2_q;
    logic cap_acc1_q;
    logic cap_acc2_q;

    // A completed access, the only thing allowed to clear a flag
    assign done = psel && penable && pready;

    // Recent accesses to the places whose reads clear flags
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_acc1_q <= 1'b0;
            csr_acc2_q <= 1'b0;
            cap_acc1_q <= 1'b0;
            cap_acc2_q <= 1'b0;
        end else begin
            csr_acc1_q <= done && paddr == `PAT_OFS_CSR;
            csr_acc2_q <= csr_acc1_q;
            cap_acc1_q <= done && paddr >= `PAT_OFS_ICCSR && paddr <= `PAT_OFS_ICR2;
            cap_acc2_q <= cap_acc1_q;
        end
    end

    chk_oe_gates_out: assert property ((pulse_out & ~pulse_oe & ~$past(pulse_oe)) == 4'h0)
        else $error("pulse output active on a disabled channel");
    chk_force_reads_zero: assert property (done && !pwrite && paddr == `PAT_OFS_CSR |-> !prdata[2])
        else $error("force reload bit read as one");
    chk_ovf_irq_clear: assert property ($fell(overflow_irq) |-> csr_acc1_q || csr_acc2_q)
        else $error("overflow request fell without a status access");
    chk_cap_irq_clear: assert property ($fell(capture_irq) |-> cap_acc1_q || cap_acc2_q)
        else $error("capture request fell without a capture access");
    chk_wake_in_stop: assert property (wakeup |-> deep_stop || $past(deep_stop) || $past(deep_stop, 2))
        else $error("wakeup outside deep stop");
    chk_pwm_frozen: assert property (deep_stop [*3] |=> $stable(pulse_out) && $stable(pulse_oe))
        else $error("pulse outputs moved in deep stop");
    chk_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("access not answered after one wait state");
    chk_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
        else $error("ready outside access or longer than one cycle");
    chk_err_unmapped: assert property (pready && paddr > `PAT_OFS_ICR2 |-> pslverr)
        else $error("unmapped access without error");

    // Main scenarios reached
    cover property ($rose(overflow_irq));
    cover property ($rose(capture_irq));
    cover property (wakeup);
    cover property (pready && pslverr);
endmodule

bind pat_timer pat_timer_assertions pat_timer_assertions_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pulse_out(pulse_out), .pulse_oe(pulse_oe),
    .deep_stop(deep_stop), .overflow_irq(overflow_irq), .capture_irq(capture_irq), .wakeup(wakeup)
);

// ==== pat_pins_model.sv ====
// Pin partner of the PWM timer: event clock and two capture inputs.
// Assumes tasks are called right after a rising clk edge.
`timescale 1ns/1ns

module pat_pins_model (
    // Clock
    input wire logic clk,
    // Pins
    output logic external_tick,
    output logic [1:0] capture_pin
);
    // Idle levels: event low, channel 1 low, channel 2 high
    initial begin
        external_tick = 1'b0;
        capture_pin = 2'b10;
    end

    // Event pulses, four cycles high and four low so the filter sees each
    task automatic ext_pulses(input int n);
        repeat (n) begin
            external_tick <= 1'b1;
            repeat (4) @(posedge clk);
            external_tick <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    // New capture pin levels
    task automatic cap_set(input logic [1:0] v);
        capture_pin <= v;
        @(posedge clk);
    endtask
endmodule

// ==== testbench.sv ====
// Directed tests of the PWM timer through APB and its pins.
// Assumes pat_timer, the checker and pat_pins_model are compiled first.
`timescale 1ns/1ns
`include "pat_defs.svh"

module testbench;
    // Design signals
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic external_tick;
    logic [1:0] capture_pin;
    logic [3:0] pulse_out;
    logic [3:0] pulse_oe;
    logic deep_stop;
    logic overflow_irq;
    logic capture_irq;
    logic wakeup;
    // Bench state
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int wakes = 0;
    int rises = 0;
    logic last0 = 1'b0;
    logic [7:0] rd;
    logic [7:0] c;
    logic err;

    pat_timer pat_timer_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_tick(external_tick), .capture_pin(capture_pin), .pulse_out(pulse_out),
        .pulse_oe(pulse_oe), .deep_stop(deep_stop), .overflow_irq(overflow_irq),
        .capture_irq(capture_irq), .wakeup(wakeup));
    pat_pins_model pat_pins_model_i (.clk(clk), .external_tick(external_tick), .capture_pin(capture_pin));

    always #25 clk = ~clk;

    // Wakeups and the hang limit
    always @(posedge clk) begin
        cycles++;
        wakes += (wakeup === 1'b1);
        if (cycles == 10000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        // Upper lanes carry junk that the design must ignore
        pwdata <= {~d, ~d, ~d, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && t < 20) begin
            t++;
            @(posedge clk);
        end
        if (t == 20) begin
            n_errors++;
            $display("CHECK FAILED at %0t: no ready", $time);
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask

    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0000_0000;
        deep_stop <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Reset values, then an unmapped word
        for (int a = 0; a <= 8'h28; a += 4) begin
            rdc(8'(a), 8'h00);
        end
        apb(1'b0, 8'h2c, 8'h00);
        chk({7'h0, err}, 8'h01);
        $display("test reset values done");
        // Every divide code, five ticks each from a cleared prescaler
        for (int n = 0; n < 8; n++) begin
            wr(`PAT_OFS_CAR, 8'h00);
            wr(`PAT_OFS_CSR, {1'b0, 3'(n), 4'h8});
            repeat ((5 << n) + ((1 << n) >> 1) - 4) @(posedge clk);
            wr(`PAT_OFS_CSR, {1'b0, 3'(n), 4'h0});
            repeat (3) @(posedge clk);
            rdc(`PAT_OFS_CAR, 8'h05);
        end
        $display("test prescaler done");
        wr(`PAT_OFS_ARR, 8'h40);
        wr(`PAT_OFS_CSR, 8'h04);
        rdc(`PAT_OFS_CAR, 8'h40);
        rdc(`PAT_OFS_CSR, 8'h00);
        wr(`PAT_OFS_CAR, 8'h9a);
        rdc(`PAT_OFS_CAR, 8'h9a);
        $display("test counter access done");
        // Two channels on a 16-tick period, channel 1 inverted
        wr(`PAT_OFS_ARR, 8'hf0);
        wr(`PAT_OFS_DUTY0, 8'hf8);
        wr(`PAT_OFS_DUTY1, 8'hf4);
        wr(`PAT_OFS_PCR, 8'h32);
        wr(`PAT_OFS_CAR, 8'hf0);
        wr(`PAT_OFS_CSR, 8'h08);
        repeat (40) @(posedge clk);
        // Count rises over ten whole periods, one sample per edge
        rises = 0;
        last0 = pulse_out[0];
        repeat (160) begin
            @(posedge clk);
            rises += (pulse_out[0] === 1'b1 && last0 === 1'b0);
            last0 = pulse_out[0];
        end
        chk(8'(rises), 8'h0a);
        wr(`PAT_OFS_CSR, 8'h00);
        apb(1'b0, `PAT_OFS_CAR, 8'h00);
        c = rd;
        repeat (3) @(posedge clk);
        chk({4'h0, pulse_out}, {6'h0, c > 8'hf4, c <= 8'hf8});
        chk({4'h0, pulse_oe}, 8'h03);
        wr(`PAT_OFS_PCR, 8'h30);
        repeat (3) @(posedge clk);
        chk({7'h0, pulse_out[1]}, {7'h0, c <= 8'hf4});
        $display("test pwm done");
        // Captures on a frozen counter: rising on 1, falling on 2
        wr(`PAT_OFS_CAR, 8'h33);
        wr(`PAT_OFS_ICCSR, 8'h1c);
        pat_pins_model_i.cap_set(2'b01);
        repeat (8) @(posedge clk);
        rdc(`PAT_OFS_ICCSR, 8'h1f);
        chk({7'h0, capture_irq}, 8'h01);
        wr(`PAT_OFS_CAR, 8'h44);
        pat_pins_model_i.cap_set(2'b10);
        repeat (8) @(posedge clk);
        pat_pins_model_i.cap_set(2'b01);
        repeat (8) @(posedge clk);
        rdc(`PAT_OFS_ICR1, 8'h33);
        rdc(`PAT_OFS_ICCSR, 8'h1e);
        chk({7'h0, capture_irq}, 8'h01);
        rdc(`PAT_OFS_ICR2, 8'h33);
        pat_pins_model_i.cap_set(2'b10);
        repeat (8) @(posedge clk);
        rdc(`PAT_OFS_ICCSR, 8'h1c);
        chk({7'h0, capture_irq}, 8'h00);
        $display("test capture done");
        // Event counting, three events per overflow
        apb(1'b0, `PAT_OFS_CSR, 8'h00);
        wr(`PAT_OFS_ARR, 8'hfd);
        wr(`PAT_OFS_CAR, 8'hfd);
        wr(`PAT_OFS_CSR, 8'h8a);
        pat_pins_model_i.ext_pulses(2);
        repeat (6) @(posedge clk);
        rdc(`PAT_OFS_CAR, 8'hff);
        pat_pins_model_i.ext_pulses(1);
        repeat (6) @(posedge clk);
        chk({7'h0, overflow_irq}, 8'h01);
        rdc(`PAT_OFS_CAR, 8'hfd);
        rdc(`PAT_OFS_CSR, 8'h8b);
        rdc(`PAT_OFS_CSR, 8'h8a);
        $display("test event counting done");
        // Deep stop: frozen writes, overflow and capture wake
        deep_stop <= 1'b1;
        wr(`PAT_OFS_ARR, 8'h00);
        pat_pins_model_i.ext_pulses(3);
        repeat (6) @(posedge clk);
        pat_pins_model_i.cap_set(2'b01);
        repeat (8) @(posedge clk);
        deep_stop <= 1'b0;
        @(posedge clk);
        chk(8'(wakes), 8'h02);
        rdc(`PAT_OFS_ARR, 8'hfd);
        $display("test deep stop done");
        stop_test();
    end
endmodule
